// >>> core/bldft_defines.svh
`ifndef BLDFT_DEFINES_SVH
`define BLDFT_DEFINES_SVH

// Register map
`define BLDFT_DIM_DELAY_ADDR 8'h07
`define BLDFT_FADE_RATE_ADDR 8'h08
`define BLDFT_DIM_DELAY_RST  8'h00
`define BLDFT_FADE_RATE_RST  8'h00

// Field positions
`define BLDFT_DIM_CODE_MSB   6
`define BLDFT_DIM_CODE_LSB   0
`define BLDFT_FADE_DN_MSB    7
`define BLDFT_FADE_DN_LSB    4
`define BLDFT_FADE_UP_MSB    3
`define BLDFT_FADE_UP_LSB    0

// Timing
`define BLDFT_CLK_NS         100
`define BLDFT_SEC_NS         1000000000
`define BLDFT_SEC_CYC        (`BLDFT_SEC_NS / `BLDFT_CLK_NS)
`define BLDFT_FAST_FADE_MS   100
`define BLDFT_FADE_INC_MS    300
`define BLDFT_FULL_SCALE     127
`define BLDFT_FAST_STEP_CYC  ((`BLDFT_FAST_FADE_MS * 1000000 / `BLDFT_CLK_NS) / `BLDFT_FULL_SCALE)
`define BLDFT_UNIT_STEP_CYC  ((`BLDFT_FADE_INC_MS * 1000000 / `BLDFT_CLK_NS) / `BLDFT_FULL_SCALE)
`endif

// >>> core/bldft_interval.sv
`timescale 1ns/10ps
module bldft_interval #(
  parameter int W = 24
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Control
  input  wire logic         clear,
  input  wire logic [W-1:0] period,
  // Result
  output logic              tick
);
  logic [W-1:0] cnt_reg;
  logic [W-1:0] cnt_next;
  wire          last = cnt_reg >= (period - W'(1));

  // A period of zero would behave as 2^W cycles
  assign tick     = !clear && last;
  assign cnt_next = (clear || last) ? '0 : cnt_reg + W'(1);

  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg <= '0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
endmodule

// >>> core/bldft_pkg.sv
package bldft_pkg;
  typedef enum logic [2:0] {
    ph_off,
    ph_fade_up,
    ph_at_max,
    ph_fade_dim,
    ph_at_dim,
    ph_fade_off
  } bldft_phase_e;
endpackage

// >>> core/bldft_ramp.sv
`timescale 1ns/10ps
module bldft_ramp #(
  parameter int LW = 7
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Stepping
  input  wire logic          step,
  input  wire logic [LW-1:0] target,
  // Level
  output logic [LW-1:0]      level,
  output logic               at_target
);
  logic [LW-1:0] level_reg;
  logic [LW-1:0] level_next;
  wire           go_up = level_reg < target;
  wire           go_dn = level_reg > target;

  // One code per step, so time scales with distance
  assign level_next = !step ? level_reg :
                      go_up ? level_reg + LW'(1) :
                      go_dn ? level_reg - LW'(1) : level_reg;
  assign level      = level_reg;
  assign at_target  = level_reg == target;

  always_ff @(posedge clk) begin
    if (rst) begin
      level_reg <= '0;
    end else begin
      level_reg <= level_next;
    end
  end
endmodule

// >>> core/bldft_top.sv
`timescale 1ns/10ps
`include "bldft_defines.svh"
module bldft_top #(
  parameter int              STEP_W           = 24,
  parameter logic [23:0]     SEC_CYCLES       = 24'(`BLDFT_SEC_CYC),
  parameter logic [23:0]     FAST_STEP_CYCLES = 24'(`BLDFT_FAST_STEP_CYC),
  parameter logic [23:0]     UNIT_STEP_CYCLES = 24'(`BLDFT_UNIT_STEP_CYC)
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst,
  // Register port from serial host engine
  input  wire logic [7:0]    reg_addr,
  input  wire logic          reg_wr,
  input  wire logic [7:0]    reg_wdata,
  input  wire logic          reg_rd,
  output logic [7:0]         reg_rdata,
  // Backlight control from the rest of the chip
  input  wire logic          bl_on,
  input  wire logic [6:0]    max_current,
  input  wire logic [6:0]    dim_current,
  input  wire logic [6:0]    off_delay_code,
  // Backlight drive and status
  output logic [6:0]         bl_level,
  output bldft_pkg::bldft_phase_e bl_phase,
  output logic [6:0]         sec_count
);
  // Registers
  logic [7:0]                dim_delay_reg;
  logic [7:0]                dim_delay_next;
  logic [7:0]                fade_rate_reg;
  logic [7:0]                fade_rate_next;
  logic [7:0]                rdata_reg;
  logic [7:0]                rdata_next;
  logic                      on_prev_reg;
  logic [6:0]                sec_cnt_reg;
  logic [6:0]                sec_cnt_next;
  bldft_pkg::bldft_phase_e   phase_reg;
  bldft_pkg::bldft_phase_e   phase_next;

  // Decode
  wire sel_dim  = reg_addr == `BLDFT_DIM_DELAY_ADDR;
  wire sel_fade = reg_addr == `BLDFT_FADE_RATE_ADDR;
  wire wr_dim   = reg_wr && sel_dim;
  wire wr_fade  = reg_wr && sel_fade;

  // Fields
  wire [6:0] dim_code = dim_delay_reg[`BLDFT_DIM_CODE_MSB:`BLDFT_DIM_CODE_LSB];
  wire [3:0] dn_code  = fade_rate_reg[`BLDFT_FADE_DN_MSB:`BLDFT_FADE_DN_LSB];
  wire [3:0] up_code  = fade_rate_reg[`BLDFT_FADE_UP_MSB:`BLDFT_FADE_UP_LSB];

  // Reserved bit 7 of the dim register is not stored, reads zero
  assign dim_delay_next = wr_dim ? {1'b0, reg_wdata[6:0]} : dim_delay_reg;
  assign fade_rate_next = wr_fade ? reg_wdata : fade_rate_reg;
  assign rdata_next     = !reg_rd  ? rdata_reg :
                          sel_dim  ? dim_delay_reg :
                          sel_fade ? fade_rate_reg : 8'h00;

  // Step period per current code; full scale is 127 codes
  wire [STEP_W-1:0] dn_period =
    (dn_code == 4'h0) ? STEP_W'(FAST_STEP_CYCLES)
                      : STEP_W'(UNIT_STEP_CYCLES * STEP_W'(dn_code));
  wire [STEP_W-1:0] up_period =
    (up_code == 4'h0) ? STEP_W'(FAST_STEP_CYCLES)
                      : STEP_W'(UNIT_STEP_CYCLES * STEP_W'(up_code));

  // Phase decode
  wire in_up   = phase_reg == bldft_pkg::ph_fade_up;
  wire in_max  = phase_reg == bldft_pkg::ph_at_max;
  wire in_fdim = phase_reg == bldft_pkg::ph_fade_dim;
  wire in_dim  = phase_reg == bldft_pkg::ph_at_dim;
  wire in_foff = phase_reg == bldft_pkg::ph_fade_off;

  // Rising edge so an expired timeout is not undone by a held request
  wire start    = bl_on && !on_prev_reg;
  wire leaving  = !bl_on && on_prev_reg;
  wire dim_en   = dim_code != 7'h00;
  wire off_en   = off_delay_code != 7'h00;
  wire dim_due  = dim_en && sec_cnt_reg >= dim_code;
  wire off_due  = off_en && sec_cnt_reg >= off_delay_code;

  // Downward ramps all use the fade-down rate
  wire going_up = in_up || in_max;
  wire [STEP_W-1:0] step_period = going_up ? up_period : dn_period;
  wire [6:0] target =
    (in_up || in_max) ? max_current :
    (in_fdim || in_dim) ? dim_current : 7'h00;

  // Step timer restarts whenever the phase moves; seconds restart on entry to ph_at_max or ph_fade_dim
  wire phase_move = phase_next != phase_reg;
  wire sec_clear  = phase_move &&
                    (phase_next == bldft_pkg::ph_at_max ||
                     phase_next == bldft_pkg::ph_fade_dim);
  wire counting   = in_max || in_fdim || in_dim;
  wire sec_tick;
  wire step_tick;
  wire at_target;

  bldft_interval #(
    .W (24)
  ) u_sec (
    .clk    (clk),
    .rst    (rst),
    .clear  (sec_clear || !counting),
    .period (SEC_CYCLES),
    .tick   (sec_tick)
  );

  bldft_interval #(
    .W (STEP_W)
  ) u_step (
    .clk    (clk),
    .rst    (rst),
    .clear  (phase_move),
    .period (step_period),
    .tick   (step_tick)
  );

  // Level moves one code per step toward target, full scale is 30 mA
  bldft_ramp #(
    .LW (7)
  ) u_ramp (
    .clk       (clk),
    .rst       (rst),
    .step      (step_tick),
    .target    (target),
    .level     (bl_level),
    .at_target (at_target)
  );

  // Seconds since ph_at_max or ph_fade_dim was entered, saturating at the largest code
  assign sec_cnt_next = sec_clear ? 7'h00 :
                        (sec_tick && counting && sec_cnt_reg != 7'h7f) ?
                        sec_cnt_reg + 7'h01 : sec_cnt_reg;

  always_comb begin
    phase_next = phase_reg;
    unique case (phase_reg)
      bldft_pkg::ph_off: begin
        if (start) begin
          phase_next = bldft_pkg::ph_fade_up;
        end
      end
      bldft_pkg::ph_fade_up: begin
        if (leaving) begin
          phase_next = bldft_pkg::ph_fade_off;
        end else if (at_target) begin
          phase_next = bldft_pkg::ph_at_max;
        end
      end
      bldft_pkg::ph_at_max: begin
        if (leaving) begin
          phase_next = bldft_pkg::ph_fade_off;
        end else if (dim_due) begin
          phase_next = bldft_pkg::ph_fade_dim;
        end else if (!dim_en && off_due) begin
          phase_next = bldft_pkg::ph_fade_off;
        end
      end
      bldft_pkg::ph_fade_dim: begin
        if (leaving || off_due) begin
          phase_next = bldft_pkg::ph_fade_off;
        end else if (at_target) begin
          phase_next = bldft_pkg::ph_at_dim;
        end
      end
      bldft_pkg::ph_at_dim: begin
        if (leaving || off_due) begin
          phase_next = bldft_pkg::ph_fade_off;
        end
      end
      bldft_pkg::ph_fade_off: begin
        if (start) begin
          phase_next = bldft_pkg::ph_fade_up;
        end else if (at_target) begin
          phase_next = bldft_pkg::ph_off;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      dim_delay_reg <= `BLDFT_DIM_DELAY_RST;
      fade_rate_reg <= `BLDFT_FADE_RATE_RST;
      rdata_reg     <= 8'h00;
      on_prev_reg   <= 1'b0;
      sec_cnt_reg   <= 7'h00;
      phase_reg     <= bldft_pkg::ph_off;
    end else begin
      dim_delay_reg <= dim_delay_next;
      fade_rate_reg <= fade_rate_next;
      rdata_reg     <= rdata_next;
      on_prev_reg   <= bl_on;
      sec_cnt_reg   <= sec_cnt_next;
      phase_reg     <= phase_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign bl_phase  = phase_reg;
  assign sec_count = sec_cnt_reg;
endmodule

// >>> dv/bldft_host.sv
`timescale 1ns/10ps
module bldft_host (
  // Clock and read data
  input  logic       clk,
  input  logic [7:0] reg_rdata,
  // Register strobes
  output logic [7:0] reg_addr,
  output logic       reg_wr,
  output logic [7:0] reg_wdata,
  output logic       reg_rd
);
  initial begin
    reg_addr = 8'h00;
    reg_wr = 1'b0;
    reg_wdata = 8'h00;
    reg_rd = 1'b0;
  end
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge clk) #1;
    reg_wr = 1'b0;
    // Stale data inverted so a late sample cannot pass by luck
    reg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk) #1;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    @(posedge clk) #1;
    d = reg_rdata;
  endtask
endmodule

// >>> dv/bldft_top_assertions.sv
`timescale 1ns/10ps
module bldft_chk (
  // Clock and reset
  input logic                    clk,
  input logic                    rst,
  // Register port
  input logic [7:0]              reg_addr,
  input logic                    reg_wr,
  input logic [7:0]              reg_wdata,
  input logic                    reg_rd,
  input logic [7:0]              reg_rdata,
  // Backlight
  input logic                    bl_on,
  input logic [6:0]              max_current,
  input logic [6:0]              dim_current,
  input logic [6:0]              bl_level,
  input bldft_pkg::bldft_phase_e bl_phase,
  input logic [6:0]              sec_count
);
  logic [7:0] dim_reg;
  logic [7:0] fr_reg;
  logic [7:0] exp_reg;
  wire  [7:0] rd_next = reg_addr == 8'h07 ? dim_reg : reg_addr == 8'h08 ? fr_reg : 8'h00;
  wire        at_max  = bl_phase == bldft_pkg::ph_at_max;
  wire        f_dim   = bl_phase == bldft_pkg::ph_fade_dim;
  wire        at_dim  = bl_phase == bldft_pkg::ph_at_dim;
  wire        dim_off = dim_reg[6:0] == 7'h00;
  // Shadow copy, so read data is judged without peeking inside
  always_ff @(posedge clk) begin
    if (rst) begin
      dim_reg <= 8'h00;
      fr_reg  <= 8'h00;
      exp_reg <= 8'h00;
    end else begin
      if (reg_wr && reg_addr == 8'h07) dim_reg <= {1'b0, reg_wdata[6:0]};
      if (reg_wr && reg_addr == 8'h08) fr_reg <= reg_wdata;
      if (reg_rd) exp_reg <= rd_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_rd; $past(reg_rd) |-> reg_rdata == exp_reg; endproperty
  property p_max; at_max |-> bl_level == max_current; endproperty
  property p_entry; $rose(at_max) |-> sec_count == 7'h00; endproperty
  property p_dim; at_max && bl_on && !dim_off && sec_count == dim_reg[6:0] |=> f_dim;
  endproperty
  property p_nodim; at_max && dim_off |=> !f_dim; endproperty
  property p_lvl; at_dim |-> bl_level == dim_current; endproperty
  property p_sec; at_max && $past(at_max) && $changed(sec_count)
    |-> sec_count == $past(sec_count) + 7'h01; endproperty
  property p_down; f_dim && $past(f_dim)
    |-> bl_level == $past(bl_level) || bl_level == $past(bl_level) - 7'h01; endproperty
  a_rd: assert property (p_rd) else $error("read data wrong");
  a_max: assert property (p_max) else $error("level not at maximum");
  a_entry: assert property (p_entry) else $error("count not cleared at max");
  a_dim: assert property (p_dim) else $error("dim not started");
  a_nodim: assert property (p_nodim) else $error("dim while disabled");
  a_lvl: assert property (p_lvl) else $error("dim level wrong");
  a_sec: assert property (p_sec) else $error("second count jumped");
  a_down: assert property (p_down) else $error("ramp step wrong");
  c_dim: cover property (f_dim);
  c_off: cover property (bl_phase == bldft_pkg::ph_fade_off);
  c_rd: cover property (reg_rd);
endmodule
bind bldft_top bldft_chk u_chk (.clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata,
  .bl_on, .max_current, .dim_current, .bl_level, .bl_phase, .sec_count);

// >>> dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic                    clk, rst, bl_on, reg_wr, reg_rd;
  logic [7:0]              reg_addr, reg_wdata, reg_rdata, rdv;
  logic [6:0]              off_code, bl_level, sec_count;
  bldft_pkg::bldft_phase_e bl_phase;
  int                      mismatches, checked, t;
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  bldft_host host (.clk, .reg_rdata, .reg_addr, .reg_wr, .reg_wdata, .reg_rd);
  // Short second and step periods keep the run brief
  bldft_top #(.SEC_CYCLES(24'h14), .FAST_STEP_CYCLES(24'h2), .UNIT_STEP_CYCLES(24'h3)) uut (
    .clk, .rst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata, .bl_on,
    .max_current(7'h14), .dim_current(7'h0a), .off_delay_code(off_code), .bl_level,
    .bl_phase, .sec_count);
  task end_sim;
    $display("checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task chk8(input string n, input logic [7:0] e, g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  // Slack of 8 cycles covers phase entry latency, not a whole slow step
  task chkt(input string n, input int e, g);
    checked++;
    if (g > e + 8 || g + 8 < e) begin
      mismatches++;
      $display("BAD %s expected %0d seen %0d", n, e, g);
    end
  endtask
  task span(input bldft_pkg::bldft_phase_e p);
    t = 0;
    while (bl_phase !== p && t < 5000) begin
      @(posedge clk) #1;
      t++;
    end
  endtask
  task rdc(input string n, input logic [7:0] a, e);
    host.rd(a, rdv);
    chk8(n, e, rdv);
  endtask
  task trial(input logic [7:0] d, f, input int up, hold, dn);
    host.wr(8'h07, d);
    host.wr(8'h08, f);
    bl_on = 1'b1;
    span(bldft_pkg::ph_at_max);
    chkt("fade up", up, t);
    span(bldft_pkg::ph_fade_dim);
    chkt("dim delay", hold, t);
    span(bldft_pkg::ph_at_dim);
    chkt("fade down", dn, t);
    bl_on = 1'b0;
    span(bldft_pkg::ph_off);
    chk8("level off", 8'h00, {1'b0, bl_level});
    $display("trial %h %h done", d, f);
  endtask
  initial begin
    rst = 1'b1;
    bl_on = 1'b0;
    off_code = 7'h00;
    mismatches = 0;
    checked = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    chk8("level", 8'h00, {1'b0, bl_level});
    chk8("phase", 8'h00, {5'h00, bl_phase});
    rdc("dim reset", 8'h07, 8'h00);
    rdc("fade reset", 8'h08, 8'h00);
    host.wr(8'h07, 8'hff);
    rdc("dim bits", 8'h07, 8'h7f);
    host.wr(8'h08, 8'ha5);
    rdc("fade bits", 8'h08, 8'ha5);
    host.wr(8'h09, 8'h33);
    rdc("unmapped", 8'h09, 8'h00);
    $display("registers done");
    trial(8'h01, 8'h02, 120, 20, 20);
    trial(8'h82, 8'h10, 40, 40, 30);
    trial(8'h03, 8'h21, 60, 60, 60);
    trial(8'h01, 8'h00, 40, 20, 20);
    // A one second off delay ties with this dim fade, so the dim level is skipped
    off_code = 7'h01;
    host.wr(8'h07, 8'h01);
    bl_on = 1'b1;
    span(bldft_pkg::ph_fade_dim);
    span(bldft_pkg::ph_fade_off);
    chkt("off after dim", 20, t);
    bl_on = 1'b0;
    span(bldft_pkg::ph_off);
    $display("off delay done");
    off_code = 7'h02;
    host.wr(8'h07, 8'h00);
    bl_on = 1'b1;
    span(bldft_pkg::ph_at_max);
    span(bldft_pkg::ph_fade_off);
    chkt("dim disabled", 40, t);
    bl_on = 1'b0;
    span(bldft_pkg::ph_off);
    $display("dim disabled done");
    host.wr(8'h08, 8'h5a);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    chk8("phase after reset", 8'h00, {5'h00, bl_phase});
    rdc("fade after reset", 8'h08, 8'h00);
    $display("reset done");
    end_sim;
  end
  initial begin
    #(100 * 20000);
    mismatches++;
    end_sim;
  end
endmodule
